/* File: design/iso_rx_pkg.sv */
// Purpose: Shared constants for the isochronous receiver control block
// Assumes: 250 MHz core clock, 8-bit byte address register port
// Notes: Offsets are byte addresses
package iso_rx_pkg;

  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_UNPACK_CTRL = 8'h40;
  localparam logic [7:0] OFS_HDR_ONE = 8'h44;
  localparam logic [7:0] OFS_HDR_TWO = 8'h48;
  localparam logic [7:0] OFS_INT_FLAGS = 8'h4C;
  localparam logic [7:0] OFS_INT_MASK = 8'h50;

  localparam logic [31:0] RST_UNPACK_CTRL = 32'h00000041;
  localparam logic [31:0] RST_HDR_ONE = 32'h00000000;
  localparam logic [31:0] RST_HDR_TWO = 32'h0000FFFF;
  localparam logic [14:0] INT_BITS_USED = 15'h47FF;

  // Control field positions
  localparam int POS_CLK_SEL = 28;
  localparam int POS_SEND_IMM = 8;
  localparam int POS_STAMP_DIS = 7;
  localparam int POS_DROP_UNREL = 6;
  localparam int POS_SRC_READY = 5;
  localparam int POS_RX_EN = 4;
  localparam int POS_BYTE_PAD = 2;
  localparam int POS_SYNC_EN = 1;
  localparam int POS_RX_RST = 0;

  // Interrupt flag positions
  localparam int IRQ_STAMP_OVF = 14;
  localparam int IRQ_LVL_A = 10;
  localparam int IRQ_LVL_B = 9;
  localparam int IRQ_LVL_C = 8;
  localparam int IRQ_BANK_FULL = 7;
  localparam int IRQ_BANK_EMPTY = 6;
  localparam int IRQ_FSYNC = 5;
  localparam int IRQ_SEQ_ERR = 4;
  localparam int IRQ_CRC_ERR = 3;
  localparam int IRQ_TAG_FAULT = 2;
  localparam int IRQ_PKT_DONE = 1;
  localparam int IRQ_SQ_OVF = 0;

  // Queue space thresholds in quadlets
  localparam logic [15:0] LVL_A_QUADS = 16'h0064;
  localparam logic [15:0] LVL_B_QUADS = 16'h0100;
  localparam logic [15:0] LVL_C_QUADS = 16'h0200;

  // Header tag codes
  localparam logic [1:0] TAG_HDR_ONE = 2'h0;
  localparam logic [1:0] TAG_HDR_TWO = 2'h2;

  // Application clock synthesis: phase step = f_out * 2^32 / f_core
  localparam longint CORE_HZ = 250000000;
  localparam longint APP_HZ_FAST = 24576000;
  localparam logic [31:0] STEP_FAST = 32'((APP_HZ_FAST << 32) / CORE_HZ);
  localparam logic [31:0] STEP_MID = 32'(((APP_HZ_FAST / 2) << 32) / CORE_HZ);
  localparam logic [31:0] STEP_SLOW = 32'(((APP_HZ_FAST / 4) << 32) / CORE_HZ);

  typedef enum logic [1:0] {
    CLK_INPUT = 2'h0,
    CLK_FAST = 2'h1,
    CLK_MID = 2'h2,
    CLK_SLOW = 2'h3
  } clk_sel_type;

  typedef enum logic [1:0] {
    RR_IDLE = 2'h0,
    RR_HOLD = 2'h1,
    RR_DONE = 2'h3
  } rst_state_type;

endpackage

/* File: design/app_clock_gen.sv */
// Purpose: Phase accumulator that synthesises the application clock
// Assumes: Runs on the core clock, output is a level with a rise pulse
// Notes: Output jitter is one core period, fine for a reference clock
module app_clock_gen (
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire iso_rx_pkg::clk_sel_type i_sel,
  output logic o_clk_level,
  output logic o_clk_rise
);
  import iso_rx_pkg::*;

  logic [31:0] phase_r;
  logic [31:0] step;

  always_comb begin
    unique case (i_sel)
      CLK_FAST: step = STEP_FAST;
      CLK_MID: step = STEP_MID;
      CLK_SLOW: step = STEP_SLOW;
      CLK_INPUT: step = 32'h00000000;
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst || i_sel == CLK_INPUT) begin
      phase_r <= 32'h00000000;
    end else begin
      phase_r <= phase_r + step;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_clk_level <= 1'b0;
      o_clk_rise <= 1'b0;
    end else begin
      o_clk_level <= phase_r[31];
      o_clk_rise <= phase_r[31] && !o_clk_level;
    end
  end

endmodule

/* File: design/iso_av_receiver_control.sv */
// Purpose: Control and status registers of the isochronous AV receiver
// Assumes: Datapath on the same clock delivers event pulses and levels
// Notes: Flags clear by writing one; a new event in that cycle wins
//
// Behaviour
// - Clock select: 00 input, 01 24.576, 10 12.288, 11 6.144 MHz.
// - Nonzero clock select drives the selected clock out of the AV clock pin while receiver enable bit 4 is set.
// - Send-immediately set: CRC-error packets skip time stamp; reset value 0.
// - Stamp check disable bit 7 skips checking, stamp precedes packet data.
// - Bit 6 drops unreliable packets from buffer memory instead of delivery.
// - Read-only bit 5 shows a source packet is ready for delivery.
// - Receiver enable bit 4 is sampled only when a new bus packet arrives.
// - Bits 3..2 strip 0 to 3 pad bytes from each last data quadlet.
// - Bit 1 enables processing of received SYT stamps.
// - With SYT enabled, low 16 bits of header two are the SYT value.
// - Header one holds the last received header; sender node in 29..24.
// - Block size in bits 23..16 in quadlets; zero means 256.
// - Fraction bits 15..14 give 1, 2, 4 or 8 blocks per packet.
// - Header one bits 13..11 dummy quadlets; bit 10 stamp precedes packets.
// - End and format bits read 00 in header one, expected 10 in two.
// - SYT FIFO overflow clears that FIFO and sets flag bit 14.
// - Flags 10, 9, 8 at 100, 256, 512 quadlets left; 512 off for 0.5K.
// - Flag 7 on data bank full, flag 6 on bank empty.
// - Flag 2 on bad header tag bits; the whole packet is ignored.
// - Flags: sync pulse 5, sequence 4, CRC 3, done 1, status overflow 0.
// - Mask bits 14..0 individually enable the matching flags.
// - Clock select sits in bits 29..28; default 00 leaves pin an input.
//
// Local design decision: strobed register access.
module iso_av_receiver_control (
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  // Register port
  input wire logic [iso_rx_pkg::ADDR_W-1:0] i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  input wire logic i_reg_write,
  input wire logic i_reg_read,
  output logic [31:0] o_reg_rdata,
  // Receive datapath events and levels
  input wire logic i_pkt_arrive,
  input wire logic i_hdr_valid,
  input wire logic [31:0] i_hdr_one,
  input wire logic [31:0] i_hdr_two,
  input wire logic i_pkt_done,
  input wire logic i_crc_error,
  input wire logic i_seq_error,
  input wire logic i_fsync_pulse,
  input wire logic i_stamp_fifo_overflow,
  input wire logic i_status_queue_overflow,
  input wire logic i_bank_full,
  input wire logic i_bank_empty,
  input wire logic [15:0] i_space_left,
  input wire logic i_half_k_buffer,
  input wire logic i_source_packet_ready,
  // AV clock pin
  input wire logic i_port_clock_pin,
  output logic o_port_clock_pin,
  output logic o_port_clock_pin_oe,
  // Controls towards the datapath
  output logic o_receiver_active,
  output logic o_send_immediately,
  output logic o_stamp_check_disable,
  output logic o_drop_unreliable,
  output logic [1:0] o_byte_pad_strip,
  output logic o_sync_stamp_enable,
  output logic [15:0] o_syt_value,
  output logic o_syt_valid,
  output logic [8:0] o_block_quadlets,
  output logic [3:0] o_blocks_per_packet,
  output logic o_packet_ignore,
  output logic o_stamp_fifo_clear,
  output logic o_receiver_reset,
  output logic o_irq
);
  import iso_rx_pkg::*;

  // ----------------------------------------
  // Control register
  // ----------------------------------------
  clk_sel_type clk_sel_r;
  logic send_imm_r;
  logic stamp_dis_r;
  logic drop_unrel_r;
  logic rx_en_r;
  logic [1:0] byte_pad_r;
  logic sync_en_r;
  logic rx_rst_bit_r;
  logic wr_ctrl;
  logic wr_flags;
  logic wr_mask;

  assign wr_ctrl = i_reg_write && i_reg_addr == OFS_UNPACK_CTRL;
  assign wr_flags = i_reg_write && i_reg_addr == OFS_INT_FLAGS;
  assign wr_mask = i_reg_write && i_reg_addr == OFS_INT_MASK;

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      clk_sel_r <= clk_sel_type'(RST_UNPACK_CTRL[POS_CLK_SEL +: 2]);
      send_imm_r <= RST_UNPACK_CTRL[POS_SEND_IMM];
      stamp_dis_r <= RST_UNPACK_CTRL[POS_STAMP_DIS];
      drop_unrel_r <= RST_UNPACK_CTRL[POS_DROP_UNREL];
      rx_en_r <= RST_UNPACK_CTRL[POS_RX_EN];
      byte_pad_r <= RST_UNPACK_CTRL[POS_BYTE_PAD +: 2];
      sync_en_r <= RST_UNPACK_CTRL[POS_SYNC_EN];
      rx_rst_bit_r <= RST_UNPACK_CTRL[POS_RX_RST];
    end else if (wr_ctrl) begin
      clk_sel_r <= clk_sel_type'(i_reg_wdata[POS_CLK_SEL +: 2]);
      send_imm_r <= i_reg_wdata[POS_SEND_IMM];
      stamp_dis_r <= i_reg_wdata[POS_STAMP_DIS];
      drop_unrel_r <= i_reg_wdata[POS_DROP_UNREL];
      rx_en_r <= i_reg_wdata[POS_RX_EN];
      byte_pad_r <= i_reg_wdata[POS_BYTE_PAD +: 2];
      sync_en_r <= i_reg_wdata[POS_SYNC_EN];
      rx_rst_bit_r <= i_reg_wdata[POS_RX_RST];
    end
  end

  // Static controls go straight to the datapath
  assign o_send_immediately = send_imm_r;
  assign o_stamp_check_disable = stamp_dis_r;
  assign o_drop_unreliable = drop_unrel_r;
  assign o_byte_pad_strip = byte_pad_r;
  assign o_sync_stamp_enable = sync_en_r;

  // ----------------------------------------
  // Graceful receiver enable
  // ----------------------------------------
  // Only a packet boundary, a receiver reset or a system reset changes the state, so a packet in flight
  // finishes under the setting it started with unless one of those resets clears it.
  logic active_r;

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst || o_receiver_reset) begin
      active_r <= 1'b0;
    end else if (i_pkt_arrive) begin
      active_r <= rx_en_r;
    end
  end

  assign o_receiver_active = active_r;

  // ----------------------------------------
  // AV clock pin
  // ----------------------------------------
  logic gen_level;
  logic gen_rise;
  logic [2:0] pin_sync_r;
  logic pin_stable_r;
  logic pin_rise_r;

  app_clock_gen u_clk_gen (
    .i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst),
    .i_sel(clk_sel_r),
    .o_clk_level(gen_level),
    .o_clk_rise(gen_rise)
  );

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      pin_sync_r <= 3'h0;
    end else begin
      pin_sync_r <= {pin_sync_r[1:0], i_port_clock_pin};
    end
  end

  // Stage one feeds stage two only; stages two and three must agree
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      pin_stable_r <= 1'b0;
      pin_rise_r <= 1'b0;
    end else begin
      pin_rise_r <= 1'b0;
      if (pin_sync_r[1] == pin_sync_r[2]) begin
        pin_stable_r <= pin_sync_r[2];
        pin_rise_r <= pin_sync_r[2] && !pin_stable_r;
      end
    end
  end

  assign o_port_clock_pin = gen_level;
  assign o_port_clock_pin_oe = (clk_sel_r != CLK_INPUT) && rx_en_r;

  // ----------------------------------------
  // Receiver reset stretch
  // ----------------------------------------
  // The reset is held until one AV clock rise has been seen, so the
  // application side is reset even if the bit is pulsed too briefly.
  rst_state_type rr_state_r;
  logic av_rise;

  assign av_rise = (clk_sel_r == CLK_INPUT) ? pin_rise_r : gen_rise;

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      rr_state_r <= RR_HOLD;
    end else begin
      unique case (rr_state_r)
        RR_IDLE: if (rx_rst_bit_r) begin
          rr_state_r <= RR_HOLD;
        end
        RR_HOLD: if (av_rise) begin
          rr_state_r <= rx_rst_bit_r ? RR_DONE : RR_IDLE;
        end
        RR_DONE: if (!rx_rst_bit_r) begin
          rr_state_r <= RR_IDLE;
        end
        default: rr_state_r <= RR_IDLE;
      endcase
    end
  end

  assign o_receiver_reset = rr_state_r != RR_IDLE;

  // ----------------------------------------
  // Header capture
  // ----------------------------------------
  logic [31:0] hdr_one_r;
  logic [31:0] hdr_two_r;
  logic tag_ok;
  logic ignore_r;

  assign tag_ok = i_hdr_one[31:30] == TAG_HDR_ONE && i_hdr_two[31:30] == TAG_HDR_TWO;

  // Faulty headers are not captured, the registers keep the last good one
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst || o_receiver_reset) begin
      hdr_one_r <= RST_HDR_ONE;
      hdr_two_r <= RST_HDR_TWO;
    end else if (i_hdr_valid && active_r && tag_ok) begin
      hdr_one_r <= i_hdr_one;
      hdr_two_r <= i_hdr_two;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      ignore_r <= 1'b0;
    end else begin
      ignore_r <= i_hdr_valid && active_r && !tag_ok;
    end
  end

  assign o_packet_ignore = ignore_r;

  // ----------------------------------------
  // Header field decode
  // ----------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_block_quadlets <= 9'h100;
      o_blocks_per_packet <= 4'h1;
      o_syt_value <= 16'h0000;
      o_syt_valid <= 1'b0;
    end else begin
      o_block_quadlets <= (hdr_one_r[23:16] == 8'h00) ? 9'h100
                          : {1'b0, hdr_one_r[23:16]};
      o_blocks_per_packet <= 4'h1 << hdr_one_r[15:14];
      o_syt_value <= sync_en_r ? hdr_two_r[15:0] : 16'h0000;
      o_syt_valid <= sync_en_r;
    end
  end

  // ----------------------------------------
  // Interrupt flags
  // ----------------------------------------
  logic [14:0] flags_r;
  logic [14:0] mask_r;
  logic [14:0] events;
  logic [2:0] lvl_now;
  logic [2:0] lvl_prev_r;
  logic ovf_clear_r;

  always_comb begin
    lvl_now[0] = i_space_left <= LVL_C_QUADS && !i_half_k_buffer;
    lvl_now[1] = i_space_left <= LVL_B_QUADS;
    lvl_now[2] = i_space_left <= LVL_A_QUADS;
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      lvl_prev_r <= 3'h0;
    end else begin
      lvl_prev_r <= lvl_now;
    end
  end

  always_comb begin
    events = 15'h0000;
    events[IRQ_STAMP_OVF] = i_stamp_fifo_overflow;
    events[IRQ_LVL_A] = lvl_now[2] && !lvl_prev_r[2];
    events[IRQ_LVL_B] = lvl_now[1] && !lvl_prev_r[1];
    events[IRQ_LVL_C] = lvl_now[0] && !lvl_prev_r[0];
    events[IRQ_BANK_FULL] = i_bank_full;
    events[IRQ_BANK_EMPTY] = i_bank_empty;
    events[IRQ_FSYNC] = i_fsync_pulse;
    events[IRQ_SEQ_ERR] = i_seq_error;
    events[IRQ_CRC_ERR] = i_crc_error;
    events[IRQ_TAG_FAULT] = i_hdr_valid && active_r && !tag_ok;
    events[IRQ_PKT_DONE] = i_pkt_done;
    events[IRQ_SQ_OVF] = i_status_queue_overflow;
  end

  // Set wins over a simultaneous write-one clear
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      flags_r <= 15'h0000;
    end else begin
      flags_r <= ((flags_r & ~(wr_flags ? i_reg_wdata[14:0] : 15'h0000)) | events)
                 & INT_BITS_USED;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      mask_r <= 15'h0000;
    end else if (wr_mask) begin
      mask_r <= i_reg_wdata[14:0];
    end
  end

  // Overflowed SYT FIFO is flushed by a one-cycle clear
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      ovf_clear_r <= 1'b0;
    end else begin
      ovf_clear_r <= i_stamp_fifo_overflow;
    end
  end

  assign o_stamp_fifo_clear = ovf_clear_r;
  assign o_irq = |(flags_r & mask_r);

  // ----------------------------------------
  // Register read
  // ----------------------------------------
  logic [31:0] ctrl_view;
  logic [31:0] rd_nxt;

  always_comb begin
    ctrl_view = 32'h00000000;
    ctrl_view[POS_CLK_SEL +: 2] = clk_sel_r;
    ctrl_view[POS_SEND_IMM] = send_imm_r;
    ctrl_view[POS_STAMP_DIS] = stamp_dis_r;
    ctrl_view[POS_DROP_UNREL] = drop_unrel_r;
    ctrl_view[POS_SRC_READY] = i_source_packet_ready;
    ctrl_view[POS_RX_EN] = rx_en_r;
    ctrl_view[POS_BYTE_PAD +: 2] = byte_pad_r;
    ctrl_view[POS_SYNC_EN] = sync_en_r;
    ctrl_view[POS_RX_RST] = rx_rst_bit_r;
  end

  always_comb begin
    unique case (i_reg_addr)
      OFS_UNPACK_CTRL: rd_nxt = ctrl_view;
      OFS_HDR_ONE: rd_nxt = hdr_one_r;
      OFS_HDR_TWO: rd_nxt = hdr_two_r;
      OFS_INT_FLAGS: rd_nxt = {17'h00000, flags_r};
      OFS_INT_MASK: rd_nxt = {17'h00000, mask_r};
      default: rd_nxt = 32'h00000000;
    endcase
  end

  // Read data stands for the one cycle after the strobe, else zero
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_reg_rdata <= 32'h00000000;
    end else begin
      o_reg_rdata <= i_reg_read ? rd_nxt : 32'h00000000;
    end
  end

endmodule

/* File: test/iso_av_receiver_control_asserts.sv */
// Purpose: Port-level checks of the receiver control block
// Assumes: One core clock, synchronous active-high reset
// Notes: Bound to every instance of the block
module iso_av_receiver_control_asserts (
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic [iso_rx_pkg::ADDR_W-1:0] i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  input wire logic i_reg_write,
  input wire logic i_pkt_arrive,
  input wire logic i_hdr_valid,
  input wire logic [31:0] i_hdr_one,
  input wire logic [31:0] i_hdr_two,
  input wire logic i_stamp_fifo_overflow,
  input wire logic o_port_clock_pin_oe,
  input wire logic o_receiver_active,
  input wire logic o_send_immediately,
  input wire logic o_stamp_check_disable,
  input wire logic o_drop_unreliable,
  input wire logic [1:0] o_byte_pad_strip,
  input wire logic o_sync_stamp_enable,
  input wire logic [15:0] o_syt_value,
  input wire logic [8:0] o_block_quadlets,
  input wire logic [3:0] o_blocks_per_packet,
  input wire logic o_packet_ignore,
  input wire logic o_stamp_fifo_clear,
  input wire logic o_receiver_reset
);
  import iso_rx_pkg::*;
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);
  // ----------------------------------------
  // Sequences
  // ----------------------------------------
  sequence s_ctrl_write;
    i_reg_write && i_reg_addr == OFS_UNPACK_CTRL;
  endsequence
  sequence s_bad_header;
    i_hdr_valid && o_receiver_active &&
      (i_hdr_one[31:30] != TAG_HDR_ONE || i_hdr_two[31:30] != TAG_HDR_TWO);
  endsequence
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_pad_write: assert property (
    s_ctrl_write |=> o_byte_pad_strip == $past(i_reg_wdata[3:2]))
    else $error("pad field not taken from write");
  a_ctrl_bits: assert property (
    s_ctrl_write |=> {o_send_immediately, o_stamp_check_disable, o_drop_unreliable,
      o_sync_stamp_enable} == {$past(i_reg_wdata[8:6]), $past(i_reg_wdata[1])})
    else $error("control bits not taken from write");
  a_pin_input: assert property (
    s_ctrl_write ##0 i_reg_wdata[29:28] == 2'h0 |=> !o_port_clock_pin_oe)
    else $error("clock pin driven in input mode");
  a_pin_drive: assert property (
    s_ctrl_write ##0 (i_reg_wdata[29:28] != 2'h0 && i_reg_wdata[4]) |=> o_port_clock_pin_oe)
    else $error("clock pin not driven");
  a_enable_held: assert property (
    (!i_pkt_arrive && !o_receiver_reset) ##1 !o_receiver_reset |-> $stable(o_receiver_active))
    else $error("receiver active changed without packet");
  a_tag_ignore: assert property (
    s_bad_header |=> o_packet_ignore)
    else $error("bad header not ignored");
  a_ignore_cause: assert property (
    o_packet_ignore |-> $past(i_hdr_valid))
    else $error("ignore without header");
  a_block_range: assert property (
    o_block_quadlets inside {[9'h001:9'h100]})
    else $error("block size out of range");
  a_frac_onehot: assert property (
    $onehot(o_blocks_per_packet))
    else $error("blocks per packet not a power of two");
  a_syt_gate: assert property (
    !$past(o_sync_stamp_enable) |-> o_syt_value == 16'h0000)
    else $error("stamp value shown while disabled");
  a_fifo_clear: assert property (
    i_stamp_fifo_overflow |=> o_stamp_fifo_clear)
    else $error("stamp fifo not cleared");
endmodule

bind iso_av_receiver_control iso_av_receiver_control_asserts u_chk (.i_core_clk, .i_sys_rst,
  .i_reg_addr, .i_reg_wdata, .i_reg_write, .i_pkt_arrive, .i_hdr_valid, .i_hdr_one,
  .i_hdr_two, .i_stamp_fifo_overflow, .o_port_clock_pin_oe, .o_receiver_active,
  .o_send_immediately, .o_stamp_check_disable, .o_drop_unreliable, .o_byte_pad_strip,
  .o_sync_stamp_enable, .o_syt_value, .o_block_quadlets, .o_blocks_per_packet,
  .o_packet_ignore, .o_stamp_fifo_clear, .o_receiver_reset);

/* File: test/av_app_model.sv */
// Purpose: Application side that supplies the AV clock
// Assumes: Source unrelated in phase to the core clock
// Notes: Never stops, so a receiver reset can always finish
module av_app_model (
  output logic o_app_clk
);
  timeunit 1ns;
  timeprecision 1ps;
  // Clock keeps running through receiver reset
  initial begin
    o_app_clk = 1'b0;
    forever #20.3 o_app_clk = ~o_app_clk;
  end
endmodule

/* File: test/iso_av_receiver_control_test.sv */
// Purpose: Self-checking bench of the receiver control block
// Assumes: 250 MHz core clock, application clock from the model
// Notes: Event inputs share one vector, bit 8 arrival, bit 9 header
module iso_av_receiver_control_test;
  import iso_rx_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_core_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd_en = 1'b0;
  logic [9:0] ev = 10'h000;
  logic [31:0] h1 = 32'h0;
  logic [31:0] h2 = 32'h0;
  logic [15:0] space = 16'h03E8;
  logic half_k = 1'b0;
  logic spr = 1'b0;
  logic [31:0] rdata;
  logic app_clk, pin, pin_oe, active, ign, rrst, irq;
  logic [15:0] syt;
  logic sytv;
  logic [8:0] bq;
  logic [3:0] bpp;
  logic [1:0] pad;
  int n_errors = 0;
  int checks_done = 0;
  int fpos[8] = '{IRQ_PKT_DONE, IRQ_CRC_ERR, IRQ_SEQ_ERR, IRQ_FSYNC, IRQ_STAMP_OVF,
    IRQ_SQ_OVF, IRQ_BANK_FULL, IRQ_BANK_EMPTY};

  always #2 i_core_clk = ~i_core_clk;

  av_app_model app (.o_app_clk(app_clk));

  iso_av_receiver_control dut (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst),
    .i_reg_addr(addr), .i_reg_wdata(wdata), .i_reg_write(wr), .i_reg_read(rd_en),
    .o_reg_rdata(rdata), .i_pkt_arrive(ev[8]), .i_hdr_valid(ev[9]), .i_hdr_one(h1),
    .i_hdr_two(h2), .i_pkt_done(ev[0]), .i_crc_error(ev[1]), .i_seq_error(ev[2]),
    .i_fsync_pulse(ev[3]), .i_stamp_fifo_overflow(ev[4]), .i_status_queue_overflow(ev[5]),
    .i_bank_full(ev[6]), .i_bank_empty(ev[7]), .i_space_left(space),
    .i_half_k_buffer(half_k), .i_source_packet_ready(spr), .i_port_clock_pin(app_clk),
    .o_port_clock_pin(pin), .o_port_clock_pin_oe(pin_oe), .o_receiver_active(active),
    .o_send_immediately(), .o_stamp_check_disable(), .o_drop_unreliable(),
    .o_byte_pad_strip(pad), .o_sync_stamp_enable(), .o_syt_value(syt), .o_syt_valid(sytv),
    .o_block_quadlets(bq), .o_blocks_per_packet(bpp), .o_packet_ignore(ign),
    .o_stamp_fifo_clear(), .o_receiver_reset(rrst), .o_irq(irq));

  // ----------------------------------------
  // Bus and check helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_core_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge i_core_clk);
    wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge i_core_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge i_core_clk);
    rd_en <= 1'b0;
    #1 chk(rdata, e);
  endtask
  task automatic pulse(input int i);
    @(posedge i_core_clk);
    ev[i] <= 1'b1;
    @(posedge i_core_clk);
    ev[i] <= 1'b0;
    #1;
  endtask
  task automatic lvl(input logic [15:0] s, input logic [31:0] e);
    @(posedge i_core_clk);
    space <= s;
    repeat (2) @(posedge i_core_clk);
    rd_chk(OFS_INT_FLAGS, e);
    wr_reg(OFS_INT_FLAGS, 32'h00007FFF);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset_vals();
    rd_chk(OFS_UNPACK_CTRL, RST_UNPACK_CTRL);
    rd_chk(OFS_HDR_ONE, RST_HDR_ONE);
    rd_chk(OFS_HDR_TWO, RST_HDR_TWO);
    rd_chk(OFS_INT_FLAGS, 32'h0);
    rd_chk(OFS_INT_MASK, 32'h0);
    rd_chk(8'h54, 32'h0);
    wr_reg(OFS_HDR_ONE, 32'hFFFFFFFF);
    rd_chk(OFS_HDR_ONE, RST_HDR_ONE);
    chk({31'h0, pin_oe}, 32'h0);
  endtask
  task automatic t_enable();
    int n;
    @(posedge i_core_clk);
    spr <= 1'b1;
    wr_reg(OFS_UNPACK_CTRL, 32'h00000010);
    for (n = 0; n < 100 && rrst !== 1'b0; n++) @(posedge i_core_clk);
    #1 chk({31'h0, rrst}, 32'h0);
    chk({31'h0, active}, 32'h0);
    pulse(8);
    chk({31'h0, active}, 32'h1);
    rd_chk(OFS_UNPACK_CTRL, 32'h00000030);
    // Clearing enable waits for the next packet
    wr_reg(OFS_UNPACK_CTRL, 32'h0);
    #1 chk({31'h0, active}, 32'h1);
    pulse(8);
    chk({31'h0, active}, 32'h0);
    wr_reg(OFS_UNPACK_CTRL, 32'h00000010);
    pulse(8);
  endtask
  task automatic t_ctrl_bits();
    wr_reg(OFS_UNPACK_CTRL, 32'h000001FE);
    rd_chk(OFS_UNPACK_CTRL, 32'h000001FE);
    for (int p = 0; p < 4; p++) begin
      wr_reg(OFS_UNPACK_CTRL, (32'(p) << POS_BYTE_PAD) | 32'h10);
      #1 chk({30'h0, pad}, 32'(p));
    end
  endtask
  task automatic t_header();
    wr_reg(OFS_UNPACK_CTRL, 32'h00000012);
    for (int f = 0; f < 4; f++) begin
      @(posedge i_core_clk);
      h1 <= {2'b00, 6'h2A, 8'(f), 2'(f), 3'h5, 1'b1, 10'h000};
      h2 <= {2'b10, 6'h10, 8'hA5, 16'h1230 + 16'(f)};
      pulse(9);
      rd_chk(OFS_HDR_ONE, h1);
      rd_chk(OFS_HDR_TWO, h2);
      chk({23'h0, bq}, (f == 0) ? 32'h100 : 32'(f));
      chk({28'h0, bpp}, 32'h1 << f);
      chk({16'h0, syt}, {16'h0, h2[15:0]});
      chk({31'h0, sytv}, 32'h1);
    end
    @(posedge i_core_clk);
    h2 <= 32'h0;
    pulse(9);
    chk({31'h0, ign}, 32'h1);
    rd_chk(OFS_HDR_TWO, {2'b10, 6'h10, 8'hA5, 16'h1233});
    rd_chk(OFS_INT_FLAGS, 32'h1 << IRQ_TAG_FAULT);
    wr_reg(OFS_INT_FLAGS, 32'h00007FFF);
  endtask
  task automatic t_events();
    wr_reg(OFS_INT_MASK, 32'h00007FFF);
    rd_chk(OFS_INT_MASK, 32'h00007FFF);
    for (int i = 0; i < 8; i++) begin
      pulse(i);
      chk({31'h0, irq}, 32'h1);
      rd_chk(OFS_INT_FLAGS, 32'h1 << fpos[i]);
      wr_reg(OFS_INT_FLAGS, 32'h1 << fpos[i]);
      #1 chk({31'h0, irq}, 32'h0);
    end
    wr_reg(OFS_INT_MASK, 32'h00007FF7);
    pulse(1);
    chk({31'h0, irq}, 32'h0);
    rd_chk(OFS_INT_FLAGS, 32'h1 << IRQ_CRC_ERR);
    wr_reg(OFS_INT_FLAGS, 32'h00007FFF);
  endtask
  task automatic t_levels();
    lvl(16'h03E8, 32'h0);
    lvl(LVL_C_QUADS, 32'h1 << IRQ_LVL_C);
    lvl(LVL_B_QUADS, 32'h1 << IRQ_LVL_B);
    lvl(LVL_A_QUADS, 32'h1 << IRQ_LVL_A);
    @(posedge i_core_clk);
    half_k <= 1'b1;
    lvl(16'h03E8, 32'h0);
    lvl(LVL_C_QUADS, 32'h0);
  endtask
  // Rise counts allow one edge of slack for the start phase
  task automatic t_clock();
    int n;
    int e;
    logic prv;
    for (int s = 1; s < 4; s++) begin
      wr_reg(OFS_UNPACK_CTRL, (32'(s) << POS_CLK_SEL) | 32'h10);
      e = int'(1000 * APP_HZ_FAST / CORE_HZ) >> (s - 1);
      n = 0;
      prv = pin;
      repeat (1000) begin
        @(negedge i_core_clk);
        if (pin && !prv) n++;
        prv = pin;
      end
      chk({31'h0, pin_oe}, 32'h1);
      chk(32'(n >= e - 1 && n <= e + 1), 32'h1);
    end
    wr_reg(OFS_UNPACK_CTRL, 32'h00000010);
    #1 chk({31'h0, pin_oe}, 32'h0);
  endtask

  task automatic close_out();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge i_core_clk);
    i_sys_rst <= 1'b0;
    t_reset_vals();
    t_enable();
    t_ctrl_bits();
    t_header();
    t_events();
    t_levels();
    t_clock();
    close_out();
  end
  initial begin
    #100000;
    n_errors++;
    close_out();
  end
endmodule
